/* sas_defines.vh */
// Purpose: Shared constants of the stream alarm supervisor
// Assumes: Byte offsets on a 32-bit AXI4-Lite register bus
// Notes:   Times are whole seconds, volumes are centilitres
`ifndef SAS_DEFINES_VH
`define SAS_DEFINES_VH

// Register byte offsets
`define SAS_ADDR_ACTION     8'h00
`define SAS_ADDR_LEAK_LIM   8'h04
`define SAS_ADDR_LEAK_PER   8'h08
`define SAS_ADDR_NOPROD_TO  8'h0c
`define SAS_ADDR_PUMP_TO    8'h10
`define SAS_ADDR_HYD_TO     8'h14
`define SAS_ADDR_VALVE_TO   8'h18
`define SAS_ADDR_PULSE_WT   8'h1c
`define SAS_ADDR_ACTIVE     8'h20
`define SAS_ADDR_IRQ_STAT   8'h24
`define SAS_ADDR_IRQ_MASK   8'h28
`define SAS_ADDR_LEAK_ACC   8'h2c

// Alarm indices, two action bits each in the action register
`define SAS_AL_LEAK     0
`define SAS_AL_NOPROD   1
`define SAS_AL_NOPUMP   2
`define SAS_AL_NOHYD    3
`define SAS_AL_VALVE    4
`define SAS_NUM_AL      5

// Action encodings
`define SAS_ACT_OFF     2'h0
`define SAS_ACT_DISP    2'h1
`define SAS_ACT_SHUT    2'h2
`define SAS_ACT_PAUSE   2'h3

// Reset values: valve, hyd, pump, noprod, leak
`define SAS_RST_ACTION  10'h13f
`define SAS_RST_LEAK_LIM 17'h00000
`define SAS_RST_LEAK_PER 7'h05
`define SAS_RST_NOPROD  8'h05
`define SAS_RST_PUMP    8'h0f
`define SAS_RST_HYD     8'h0f
`define SAS_RST_VALVE   8'h0f
`define SAS_RST_PULSE_WT 8'h01

// Ranges
`define SAS_LEAK_LIM_MAX 17'h1863c
`define SAS_LEAK_PER_MIN 7'h01
`define SAS_LEAK_PER_MAX 7'h63
`define SAS_TO_MIN      8'h01

// Timing: one second tick from the system clock
`define SAS_SECOND_NS   1000000000
`define SAS_CLK_NS      4

// AXI responses
`define SAS_RESP_OKAY   2'h0
`define SAS_RESP_SLVERR 2'h2

`endif

/* sas_timeout.v */
// Purpose: Seconds timeout for one awaited pulse or feedback
// Assumes: tick is a one-cycle pulse once per second
// Notes:   Fires once, re-arms only after a restart
`timescale 1ns/1ps
module sas_timeout #(
  parameter W = 8
) (
  input  wire         clk_sys,
  input  wire         sys_rst,
  input  wire         tick,
  input  wire         active,
  input  wire         arrive,
  input  wire [W-1:0] limit,
  output reg          expired
);

  reg [W-1:0] cnt_r;
  reg         fired_r;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r   <= {W{1'b0}};
      fired_r <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (!active || arrive) begin
        cnt_r   <= {W{1'b0}};
        fired_r <= 1'b0;
      end else if (tick && !fired_r) begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        if (cnt_r + {{(W-1){1'b0}}, 1'b1} >= limit) begin
          expired <= 1'b1;
          fired_r <= 1'b1;
        end
      end
    end
  end

endmodule // sas_timeout

/* sas_supervisor.v */
// Purpose: Per-stream alarm supervisor with AXI4-Lite registers
// Assumes: Inputs synchronous to clk_sys, meterPulse one cycle wide
// Notes:   Latched alarms clear by write-one to the active register
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "sas_defines.vh"
module sas_supervisor #(
  parameter TICK_CYCLES = `SAS_SECOND_NS / `SAS_CLK_NS,
  parameter TW          = 8,
  parameter VW          = 17
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  // Field signals
  input  wire        meterPulse,
  input  wire        streamIdle,
  input  wire        streamPermit,
  input  wire        pumpCmd,
  input  wire        pumpFb,
  input  wire        hydCmd,
  input  wire        hydFb,
  input  wire        valveCmd,
  input  wire        valveFb,
  output reg         alarmInd,
  output reg         alarmShut,
  output reg         batchStop,
  output reg         batchPause,
  output reg         irq,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam NA = `SAS_NUM_AL;

  // Byte-lane merge of a write into a register image
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  // Timeout settings stay at least one second
  function [7:0] clampTo;
    input [7:0] v;
    begin
      clampTo = (v < `SAS_TO_MIN) ? `SAS_TO_MIN : v;
    end
  endfunction

  // Configuration
  reg [2*NA-1:0] action_r;
  reg [VW-1:0]   leakLim_r;
  reg [6:0]      leakPer_r;
  reg [TW-1:0]   noProdTo_r;
  reg [TW-1:0]   pumpTo_r;
  reg [TW-1:0]   hydTo_r;
  reg [TW-1:0]   valveTo_r;
  reg [7:0]      pulseWt_r;
  reg [NA-1:0]   irqMask_r;

  // State
  reg [NA-1:0]   active_r;
  reg [NA-1:0]   irqStat_r;
  reg [31:0]     tickCnt_r;
  reg            tick_r;
  reg [6:0]      leakSec_r;
  reg [VW-1:0]   leakAcc_r;
  reg            leakFired_r;
  reg            leakEvt_r;

  // AXI state
  reg            awHeld_r;
  reg            wHeld_r;
  reg [7:0]      awAddr_r;
  reg [31:0]     wData_r;
  reg [3:0]      wStrb_r;

  wire [NA-1:0]  timeoutEvt;
  wire [NA-1:0]  rawEvt;
  reg  [NA-1:0]  evt;
  reg  [NA-1:0]  ackClr;
  reg            statRdClr;
  wire           doWrite;
  wire           doRead;
  integer        k;
  integer        m;
  wire [31:0]    actWr;
  wire [31:0]    limWr;

  // Seconds tick; counting TICK_CYCLES includes the wrap cycle
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      tickCnt_r <= 32'h0000_0000;
      tick_r    <= 1'b0;
    end else if (tickCnt_r >= TICK_CYCLES - 1) begin
      tickCnt_r <= 32'h0000_0000;
      tick_r    <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 32'h0000_0001;
      tick_r    <= 1'b0;
    end
  end

  sas_timeout #(.W(TW)) uNoProd (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .tick    (tick_r),
    .active  (streamPermit),
    .arrive  (meterPulse),
    .limit   (noProdTo_r),
    .expired (timeoutEvt[`SAS_AL_NOPROD])
  );

  sas_timeout #(.W(TW)) uPump (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .tick    (tick_r),
    .active  (pumpCmd),
    .arrive  (pumpFb),
    .limit   (pumpTo_r),
    .expired (timeoutEvt[`SAS_AL_NOPUMP])
  );

  sas_timeout #(.W(TW)) uHyd (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .tick    (tick_r),
    .active  (hydCmd),
    .arrive  (hydFb),
    .limit   (hydTo_r),
    .expired (timeoutEvt[`SAS_AL_NOHYD])
  );

  sas_timeout #(.W(TW)) uValve (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .tick    (tick_r),
    .active  (valveCmd),
    .arrive  (valveFb),
    .limit   (valveTo_r),
    .expired (timeoutEvt[`SAS_AL_VALVE])
  );

  assign timeoutEvt[`SAS_AL_LEAK] = 1'b0;
  assign rawEvt = timeoutEvt | {{(NA-1){1'b0}}, leakEvt_r};

  // Leak detector; saturates so a huge leak cannot wrap below limit
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      leakSec_r   <= 7'h00;
      leakAcc_r   <= {VW{1'b0}};
      leakFired_r <= 1'b0;
      leakEvt_r   <= 1'b0;
    end else begin
      leakEvt_r <= 1'b0;
      if (!streamIdle) begin
        leakSec_r   <= 7'h00;
        leakAcc_r   <= {VW{1'b0}};
        leakFired_r <= 1'b0;
      end else if (tick_r && (leakSec_r + 7'h01 >= leakPer_r)) begin
        leakSec_r   <= 7'h00;
        leakAcc_r   <= {VW{1'b0}};
        leakFired_r <= 1'b0;
      end else begin
        if (tick_r)
          leakSec_r <= leakSec_r + 7'h01;
        if (meterPulse) begin
          if ({1'b0, leakAcc_r} + {{(VW-7){1'b0}}, pulseWt_r}
              > {1'b0, {VW{1'b1}}})
            leakAcc_r <= {VW{1'b1}};
          else
            leakAcc_r <= leakAcc_r + {{(VW-8){1'b0}}, pulseWt_r};
        end
        if (leakAcc_r > leakLim_r && !leakFired_r) begin
          leakEvt_r   <= 1'b1;
          leakFired_r <= 1'b1;
        end
      end
    end
  end

  always @* begin
    for (k = 0; k < NA; k = k + 1)
      evt[k] = rawEvt[k] && (action_r[2*k +: 2] != `SAS_ACT_OFF);
  end

  // Alarm latches and outputs; a new event wins over its clear
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      active_r   <= {NA{1'b0}};
      alarmInd   <= 1'b0;
      alarmShut  <= 1'b0;
      batchStop  <= 1'b0;
      batchPause <= 1'b0;
    end else begin
      active_r <= (active_r & ~ackClr) | evt;
      alarmInd   <= 1'b0;
      alarmShut  <= 1'b0;
      batchStop  <= 1'b0;
      batchPause <= 1'b0;
      for (m = 0; m < NA; m = m + 1) begin
        if (active_r[m]) begin
          if (action_r[2*m +: 2] != `SAS_ACT_OFF)
            alarmInd <= 1'b1;
          if (action_r[2*m +: 2] == `SAS_ACT_SHUT) begin
            alarmShut <= 1'b1;
            batchStop <= 1'b1;
          end
          if (action_r[2*m +: 2] == `SAS_ACT_PAUSE) begin
            alarmShut  <= 1'b1;
            batchPause <= 1'b1;
          end
        end
      end
    end
  end

  // Interrupt status, cleared by reading it
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      irqStat_r <= {NA{1'b0}};
      irq       <= 1'b0;
    end else begin
      irqStat_r <= (statRdClr ? {NA{1'b0}} : irqStat_r) | evt;
      irq       <= |(((statRdClr ? {NA{1'b0}} : irqStat_r) | evt)
                     & irqMask_r);
    end
  end

  // AXI write channel
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  always @* begin
    ackClr = {NA{1'b0}};
    if (doWrite && awAddr_r == `SAS_ADDR_ACTIVE && wStrb_r[0])
      ackClr = wData_r[NA-1:0];
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SAS_RESP_OKAY;
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      awAddr_r      <= 8'h00;
      wData_r       <= 32'h0000_0000;
      wStrb_r       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r      <= s_axi_awaddr;
        awHeld_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r      <= s_axi_wdata;
        wStrb_r      <= s_axi_wstrb;
        wHeld_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr_r[1:0] != 2'h0 || awAddr_r > `SAS_ADDR_LEAK_ACC)
          s_axi_bresp <= `SAS_RESP_SLVERR;
        else
          s_axi_bresp <= `SAS_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Merged write images, cut to register width below
  assign actWr = merge({22'h0, action_r}, wData_r, wStrb_r);
  assign limWr = merge({15'h0, leakLim_r}, wData_r, wStrb_r);

  // Register writes; out-of-range settings clamp to their bounds
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      action_r   <= `SAS_RST_ACTION;
      leakLim_r  <= `SAS_RST_LEAK_LIM;
      leakPer_r  <= `SAS_RST_LEAK_PER;
      noProdTo_r <= `SAS_RST_NOPROD;
      pumpTo_r   <= `SAS_RST_PUMP;
      hydTo_r    <= `SAS_RST_HYD;
      valveTo_r  <= `SAS_RST_VALVE;
      pulseWt_r  <= `SAS_RST_PULSE_WT;
      irqMask_r  <= {NA{1'b0}};
    end else if (doWrite) begin
      if (awAddr_r == `SAS_ADDR_ACTION) begin
        action_r <= actWr[2*NA-1:0];
      end else if (awAddr_r == `SAS_ADDR_LEAK_LIM) begin
        if (limWr > {15'h0, `SAS_LEAK_LIM_MAX})
          leakLim_r <= `SAS_LEAK_LIM_MAX;
        else
          leakLim_r <= limWr[VW-1:0];
      end else if (awAddr_r == `SAS_ADDR_LEAK_PER && wStrb_r[0]) begin
        if (wData_r[7:0] < {1'b0, `SAS_LEAK_PER_MIN})
          leakPer_r <= `SAS_LEAK_PER_MIN;
        else if (wData_r[7:0] > {1'b0, `SAS_LEAK_PER_MAX})
          leakPer_r <= `SAS_LEAK_PER_MAX;
        else
          leakPer_r <= wData_r[6:0];
      end else if (awAddr_r == `SAS_ADDR_NOPROD_TO && wStrb_r[0]) begin
        noProdTo_r <= clampTo(wData_r[7:0]);
      end else if (awAddr_r == `SAS_ADDR_PUMP_TO && wStrb_r[0]) begin
        pumpTo_r <= clampTo(wData_r[7:0]);
      end else if (awAddr_r == `SAS_ADDR_HYD_TO && wStrb_r[0]) begin
        hydTo_r <= clampTo(wData_r[7:0]);
      end else if (awAddr_r == `SAS_ADDR_VALVE_TO && wStrb_r[0]) begin
        valveTo_r <= clampTo(wData_r[7:0]);
      end else if (awAddr_r == `SAS_ADDR_PULSE_WT && wStrb_r[0]) begin
        pulseWt_r <= wData_r[7:0];
      end else if (awAddr_r == `SAS_ADDR_IRQ_MASK && wStrb_r[0]) begin
        irqMask_r <= wData_r[NA-1:0];
      end
    end
  end

  // AXI read channel
  assign doRead = s_axi_arvalid && s_axi_arready;

  always @* begin
    statRdClr = doRead && (s_axi_araddr == `SAS_ADDR_IRQ_STAT);
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SAS_RESP_OKAY;
    end else begin
      if (doRead) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `SAS_RESP_OKAY;
        s_axi_rdata   <= 32'h0000_0000;
        if (s_axi_araddr == `SAS_ADDR_ACTION)
          s_axi_rdata <= {22'h0, action_r};
        else if (s_axi_araddr == `SAS_ADDR_LEAK_LIM)
          s_axi_rdata <= {15'h0, leakLim_r};
        else if (s_axi_araddr == `SAS_ADDR_LEAK_PER)
          s_axi_rdata <= {25'h0, leakPer_r};
        else if (s_axi_araddr == `SAS_ADDR_NOPROD_TO)
          s_axi_rdata <= {24'h0, noProdTo_r};
        else if (s_axi_araddr == `SAS_ADDR_PUMP_TO)
          s_axi_rdata <= {24'h0, pumpTo_r};
        else if (s_axi_araddr == `SAS_ADDR_HYD_TO)
          s_axi_rdata <= {24'h0, hydTo_r};
        else if (s_axi_araddr == `SAS_ADDR_VALVE_TO)
          s_axi_rdata <= {24'h0, valveTo_r};
        else if (s_axi_araddr == `SAS_ADDR_PULSE_WT)
          s_axi_rdata <= {24'h0, pulseWt_r};
        else if (s_axi_araddr == `SAS_ADDR_ACTIVE)
          s_axi_rdata <= {27'h0, active_r};
        else if (s_axi_araddr == `SAS_ADDR_IRQ_STAT)
          s_axi_rdata <= {27'h0, irqStat_r};
        else if (s_axi_araddr == `SAS_ADDR_IRQ_MASK)
          s_axi_rdata <= {27'h0, irqMask_r};
        else if (s_axi_araddr == `SAS_ADDR_LEAK_ACC)
          s_axi_rdata <= {15'h0, leakAcc_r};
        else
          s_axi_rresp <= `SAS_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // sas_supervisor

/* sas_supervisor_props.sv */
// Purpose: Port assertions for the alarm supervisor
// Assumes: One clock, sync active-high reset
// Notes:   Bound to the design from the bench top
`timescale 1ns/1ps
module sas_supervisor_props (
  input logic        clk_sys,
  input logic        sys_rst,
  input logic        alarmInd,
  input logic        alarmShut,
  input logic        batchStop,
  input logic        batchPause,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_wrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wrWait;
    (!s_axi_awready && !s_axi_bvalid) ##1 (s_axi_bvalid && !s_axi_wready);
  endsequence
  property p_wrWalk;
    s_wrTake |=> s_wrWait;
  endproperty
  a_wrWalk: assert property (p_wrWalk)
    else $error("write answer out of step");
  property p_bOnce;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bOnce: assert property (p_bOnce) else $error("write answer repeated");
  property p_rdWalk;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rdWalk: assert property (p_rdWalk) else $error("read answer late");
  property p_rOnce;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rOnce: assert property (p_rOnce) else $error("read answer repeated");
  // Refused reads return zero data
  property p_rRefuse;
    s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0;
  endproperty
  a_rRefuse: assert property (p_rRefuse) else $error("refused read data");
  property p_shutInd;
    alarmShut |-> alarmInd;
  endproperty
  a_shutInd: assert property (p_shutInd)
    else $error("shutdown without indication");
  property p_shutWhy;
    alarmShut == (batchStop || batchPause);
  endproperty
  a_shutWhy: assert property (p_shutWhy)
    else $error("shutdown and batch action disagree");
  // Latched indication only drops after a register write
  property p_indHold;
    $fell(alarmInd) && !$past(sys_rst) |-> $past(s_axi_bvalid);
  endproperty
  a_indHold: assert property (p_indHold)
    else $error("indication dropped without a write");
endmodule // sas_supervisor_props

/* sas_field_model.sv */
// Purpose: Field side: meter pulses and feedback contacts
// Assumes: Open contacts read low
// Notes:   Feedback delay and pulse gap set by the bench
`timescale 1ns/1ps
module sas_field_model (
  input  logic       clk_sys,
  input  logic       pumpCmd,
  input  logic       hydCmd,
  input  logic       valveCmd,
  input  logic [2:0] fbOn,
  input  logic [3:0] fbDly,
  input  logic       pulseOn,
  input  logic [3:0] pulseGap,
  output logic       pumpFb,
  output logic       hydFb,
  output logic       valveFb,
  output logic       meterPulse
);
  logic [2:0] cmdAll;
  logic [2:0] fb_r        = 3'h0;
  logic [3:0] cnt_r [3]   = '{4'h0, 4'h0, 4'h0};
  logic [3:0] gap_r       = 4'h0;
  logic       pulse_r     = 1'b0;
  assign cmdAll = {valveCmd, hydCmd, pumpCmd};
  assign {valveFb, hydFb, pumpFb} = fb_r;
  assign meterPulse = pulse_r;
  always @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (!cmdAll[i] || !fbOn[i]) begin
        cnt_r[i] <= 4'h0;
        fb_r[i]  <= 1'b0;
      end else if (cnt_r[i] == fbDly) begin
        fb_r[i] <= 1'b1;
      end else begin
        cnt_r[i] <= cnt_r[i] + 4'h1;
      end
    end
  end
  always @(posedge clk_sys) begin
    pulse_r <= pulseOn && gap_r == pulseGap;
    gap_r   <= (!pulseOn || gap_r == pulseGap) ? 4'h0 : gap_r + 4'h1;
  end
endmodule // sas_field_model

/* sas_supervisor_tb_top.sv */
// Purpose: Self-checking bench for the alarm supervisor
// Assumes: Tick shortened to 10 clocks per second
// Notes:   Bus results checked from a queue by a monitor
`timescale 1ns/1ps
module sas_supervisor_tb_top;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        streamIdle = 1'b0;
  logic        streamPermit = 1'b0;
  logic        pumpCmd = 1'b0;
  logic        hydCmd = 1'b0;
  logic        valveCmd = 1'b0;
  logic        meterPulse, pumpFb, hydFb, valveFb;
  logic        alarmInd, alarmShut, batchStop, batchPause, irq;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic        s_axi_rready = 1'b0;
  logic [2:0]  fbOn = 3'h0;
  logic [3:0]  fbDly = 4'h1;
  logic        pulseOn = 1'b0;
  logic [3:0]  pulseGap = 4'h3;
  logic [34:0] expQ [$];
  logic [4:0]  outs;
  logic [31:0] dflt [7] = '{32'h13f, 0, 5, 5, 32'hf, 32'hf, 32'hf};
  logic [7:0]  clA [4] = '{8'h04, 8'h08, 8'h08, 8'h0c};
  logic [31:0] clW [4] = '{32'd100000, 32'h0, 32'd200, 32'h0};
  logic [31:0] clE [4] = '{32'h1863c, 32'h1, 32'h63, 32'h1};
  int          err_total = 0;
  int          total_checks = 0;
  int          seed = 14812;
  int          r, k, a;
  assign outs = {alarmInd, alarmShut, batchStop, batchPause, irq};

  always #2 clk_sys = ~clk_sys;

  sas_supervisor #(.TICK_CYCLES(10)) dut_u (
    .clk_sys, .sys_rst, .meterPulse, .streamIdle, .streamPermit,
    .pumpCmd, .pumpFb, .hydCmd, .hydFb, .valveCmd, .valveFb,
    .alarmInd, .alarmShut, .batchStop, .batchPause, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );
  sas_field_model field_u (
    .clk_sys, .pumpCmd, .hydCmd, .valveCmd, .fbOn, .fbDly, .pulseOn,
    .pulseGap, .pumpFb, .hydFb, .valveFb, .meterPulse
  );

  task automatic chk(input string nm, input logic [34:0] ex,
                     input logic [34:0] got);
    total_checks++;
    if (got !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic ochk(input logic [4:0] ex);
    chk("alarm outputs", {30'h0, ex}, {30'h0, outs});
  endtask

  task automatic tally_and_finish(input bit tmo);
    if (tmo)
      err_total++;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] rs);
    int n;
    @(posedge clk_sys);
    expQ.push_back({1'b1, rs, 32'h0});
    s_axi_awaddr  <= ad;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    s_axi_bready <= 1'b0;
    if (n >= 200)
      tally_and_finish(1'b1);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] rs);
    int n;
    @(posedge clk_sys);
    expQ.push_back({1'b0, rs, d});
    s_axi_araddr  <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    if (n >= 200)
      tally_and_finish(1'b1);
  endtask

  // Bus answers matched in issue order
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready)
      chk("read", expQ.pop_front(), {1'b0, s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      chk("write", expQ.pop_front(), {1'b1, s_axi_bresp, 32'h0});
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(8'(4 * i), dflt[i], 2'h0);
    rd(8'h30, 32'h0, 2'h2);
    wr(8'h31, 32'h0, 2'h2);
    for (int i = 0; i < 4; i++) begin
      wr(clA[i], clW[i], 2'h0);
      rd(clA[i], clE[i], 2'h0);
    end
    wr(8'h08, 32'h5, 2'h0);
    wr(8'h28, 32'h1f, 2'h0);
    for (int i = 4; i < 7; i++)
      wr(8'(4 * i), 32'h3, 2'h0);
    // Three feedback alarms, one action each, then one disabled
    for (int i = 0; i < 4; i++) begin
      k = 2 + i % 3;
      a = (i + 1) % 4;
      wr(8'h00, 32'(a) << (2 * k), 2'h0);
      {valveCmd, hydCmd, pumpCmd} <= 3'h1 << (k - 2);
      waitc(15);
      ochk(5'h00);
      waitc(25);
      ochk({a != 0, a >= 2, a == 2, a == 3, a != 0});
      rd(8'h20, a != 0 ? 32'h1 << k : 32'h0, 2'h0);
      {valveCmd, hydCmd, pumpCmd} <= 3'h0;
      wr(8'h20, 32'h1f, 2'h0);
      rd(8'h24, a != 0 ? 32'h1 << k : 32'h0, 2'h0);
      rd(8'h24, 32'h0, 2'h0);
      ochk(5'h00);
    end
    wr(8'h00, 32'h3f0, 2'h0);
    r = $random(seed);
    fbDly <= 4'(r[2:0]) + 4'h1;
    fbOn <= 3'h7;
    {valveCmd, hydCmd, pumpCmd} <= 3'h7;
    waitc(60);
    ochk(5'h00);
    {valveCmd, hydCmd, pumpCmd} <= 3'h0;
    fbOn <= 3'h0;
    wr(8'h00, 32'h8, 2'h0);
    wr(8'h0c, 32'h2, 2'h0);
    r = $random(seed);
    pulseGap <= 4'(r[2:0]) + 4'h2;
    pulseOn <= 1'b1;
    streamPermit <= 1'b1;
    waitc(60);
    ochk(5'h00);
    pulseOn <= 1'b0;
    waitc(30);
    ochk(5'h1d);
    rd(8'h2c, 32'h0, 2'h0);
    streamPermit <= 1'b0;
    wr(8'h20, 32'h1f, 2'h0);
    rd(8'h24, 32'h2, 2'h0);
    // Slow drip stays under the limit only if each period restarts
    wr(8'h00, 32'h3, 2'h0);
    wr(8'h04, 32'd12, 2'h0);
    pulseGap <= 4'h9;
    streamIdle <= 1'b1;
    pulseOn <= 1'b1;
    waitc(150);
    ochk(5'h00);
    wr(8'h04, 32'h2, 2'h0);
    waitc(80);
    ochk(5'h1b);
    pulseOn <= 1'b0;
    streamIdle <= 1'b0;
    wr(8'h20, 32'h1f, 2'h0);
    rd(8'h24, 32'h1, 2'h0);
    ochk(5'h00);
    tally_and_finish(1'b0);
  end
endmodule // sas_supervisor_tb_top

bind sas_supervisor sas_supervisor_props props_u (
  .clk_sys, .sys_rst, .alarmInd, .alarmShut, .batchStop, .batchPause,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
